// >>> e1nb_pkg.sv
package e1nb_pkg;

  // register offsets
  localparam logic [7:0] OFF_INTL_ALIGN = 8'h42;
  localparam logic [7:0] OFF_INTL_NONALIGN = 8'h43;
  localparam logic [7:0] OFF_FAR_END_ALARM = 8'h44;
  localparam logic [7:0] OFF_NATIONAL_BIT4 = 8'h45;
  localparam logic [7:0] OFF_NATIONAL_BIT5 = 8'h46;
  localparam logic [7:0] OFF_NATIONAL_BIT6 = 8'h47;
  localparam logic [7:0] OFF_NATIONAL_BIT7 = 8'h48;
  localparam logic [7:0] OFF_NATIONAL_BIT8 = 8'h49;
  localparam logic [7:0] OFF_INSERT_CONTROL = 8'h4a;
  localparam logic [7:0] OFF_STATUS = 8'h4b;

  // reset values
  localparam logic [7:0] RST_FRAMES = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_READ = 8'h00;

  // bit positions: selector and timeslot-0 byte share bits 0 to 5; selector bits 6 and 7 both pick byte bit 7
  localparam int POS_NB8 = 0;
  localparam int POS_NB7 = 1;
  localparam int POS_NB6 = 2;
  localparam int POS_NB5 = 3;
  localparam int POS_NB4 = 4;
  localparam int POS_ALARM = 5;
  localparam int SEL_INTL_NONALIGN = 6;
  localparam int SEL_INTL_ALIGN = 7;
  localparam int POS_INTL = 7;
  localparam int NUM_NATIONAL = 5;

  // status register layout
  localparam int STAT_SEQ_ERR = 0;
  localparam int STAT_OUT_PENDING = 1;
  localparam int STAT_IN_READY = 2;
  localparam int STAT_LAST_LO = 4;
  localparam int STAT_LAST_HI = 7;

  // multiframe
  localparam int FRAME_W = 4;
  localparam int SLOT_W = 3;
  localparam logic [SLOT_W-1:0] SLOT_TOP = 3'h7;
  localparam logic [FRAME_W-1:0] FRAME_STEP = 4'h1;

  typedef struct packed {
    logic [FRAME_W-1:0] frame;
    logic [7:0] ts0;
  } e1nb_word_t;

endpackage

// >>> e1nb_word_if.sv
`timescale 1ns/100ps
interface e1nb_word_if;
  logic valid;
  logic ready;
  e1nb_pkg::e1nb_word_t word;

  modport src
  (
    output valid,
    output word,
    input ready
  );

  modport snk
  (
    input valid,
    input word,
    output ready
  );
endinterface

// >>> e1nb_buf2.sv
`timescale 1ns/100ps
module e1nb_buf2
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // filling side
  e1nb_word_if.snk push,
  // draining side
  e1nb_word_if.src pop
);

  logic head_valid;
  logic tail_valid;
  logic space;
  e1nb_pkg::e1nb_word_t head_word;
  e1nb_pkg::e1nb_word_t tail_word;
  logic next_head_valid;
  logic next_tail_valid;
  e1nb_pkg::e1nb_word_t next_head_word;
  e1nb_pkg::e1nb_word_t next_tail_word;
  logic do_push;
  logic do_pop;

  assign do_push = push.valid && space;
  assign do_pop = head_valid && pop.ready;
  assign push.ready = space;
  assign pop.valid = head_valid;
  assign pop.word = head_word;

  always_comb
  begin
    next_head_valid = head_valid;
    next_tail_valid = tail_valid;
    next_head_word = head_word;
    next_tail_word = tail_word;
    if (do_pop)
    begin
      next_head_valid = tail_valid;
      next_head_word = tail_word;
      next_tail_valid = 1'b0;
    end
    if (do_push)
    begin
      // a word lands in the head when the head is free after any pop
      if (!next_head_valid)
      begin
        next_head_valid = 1'b1;
        next_head_word = push.word;
      end
      else
      begin
        next_tail_valid = 1'b1;
        next_tail_word = push.word;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      head_valid <= 1'b0;
      tail_valid <= 1'b0;
      space <= 1'b1;
    end
    else
    begin
      head_valid <= next_head_valid;
      tail_valid <= next_tail_valid;
      space <= !next_tail_valid;
    end
  end

  always_ff @(posedge mclk)
  begin
    head_word <= next_head_word;
    tail_word <= next_tail_word;
  end

endmodule // e1nb_buf2

// >>> e1nb_insert.sv
// Functional notes
// R1 - control bit 0 set: national bit 8 taken from its per-frame register
// R2 - control bit 1 set: national bit 7 taken from its per-frame register
// R3 - control bit 2 set: national bit 6 taken from its per-frame register
// R4 - control bit 3 set: national bit 5 taken from its per-frame register
// R5 - control bit 4 set: national bit 4 taken from its per-frame register
// R6 - control bit 5 set: far-end alarm bit taken from its per-frame register
// R7 - control bit 6 set: non-align frame international bit from its register
// R8 - control bit 7 set: align frame international bit from its register
// R9 - national bit 4 register: bit 0 is frame 15, bit 7 is frame 1
// R10 - national bit 5 register: same odd-frame map over the multiframe
// R11 - national bits 6, 7, 8 registers: frame 15 bit 0, frame 1 bit 7
// R12 - far-end alarm register: bit 0 in frame 15, bit 7 in frame 1
// R13 - align international register: bit 7 frame 0, bit 0 frame 14
// R14 - international bit from incoming byte or the per-frame registers
// R15 - selector clear: bit passes through from the incoming timeslot-0 byte
`timescale 1ns/100ps
module e1nb_insert
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // timeslot-0 bytes from the transmit framer, default source content
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [e1nb_pkg::FRAME_W-1:0] in_frame,
  input wire logic [7:0] in_ts0,
  // timeslot-0 bytes with overhead inserted
  output logic out_valid,
  input wire logic out_ready,
  output logic [e1nb_pkg::FRAME_W-1:0] out_frame,
  output logic [7:0] out_ts0
);

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  // odd frame f and even frame f both sit at bit 7 - f/2
  function automatic logic [e1nb_pkg::SLOT_W-1:0] slot_of(input logic [e1nb_pkg::FRAME_W-1:0] frame);
    slot_of = e1nb_pkg::SLOT_TOP - frame[e1nb_pkg::FRAME_W-1:1];
  endfunction

  logic [7:0] tx_national_bit4_frames;
  logic [7:0] tx_national_bit5_frames;
  logic [7:0] tx_national_bit6_frames;
  logic [7:0] tx_national_bit7_frames;
  logic [7:0] tx_national_bit8_frames;
  logic [7:0] tx_far_end_alarm_frames;
  logic [7:0] tx_intl_bit_align_frames;
  logic [7:0] tx_intl_bit_nonalign_frames;
  logic [7:0] tx_overhead_insert_control;

  logic seq_err;
  logic have_last;
  logic [e1nb_pkg::FRAME_W-1:0] last_frame;

  logic national_bit4_insert_enable;
  logic national_bit5_insert_enable;
  logic national_bit6_insert_enable;
  logic national_bit7_insert_enable;
  logic national_bit8_insert_enable;
  logic far_end_alarm_insert_enable;
  logic intl_bit_nonalign_insert_enable;
  logic intl_bit_align_insert_enable;

  logic [7:0] national_frames [e1nb_pkg::NUM_NATIONAL];
  logic [e1nb_pkg::NUM_NATIONAL-1:0] national_enable;
  logic [e1nb_pkg::NUM_NATIONAL-1:0] national_bits;
  logic [e1nb_pkg::SLOT_W-1:0] slot;
  logic align_frame;
  logic [7:0] merged_ts0;
  logic accept;
  logic status_clear;
  logic seq_break;
  logic [7:0] status_value;
  logic [7:0] next_rdata;

  e1nb_word_if push_if ();
  e1nb_word_if pop_if ();

  // selector bits
  assign national_bit8_insert_enable = tx_overhead_insert_control[e1nb_pkg::POS_NB8];
  assign national_bit7_insert_enable = tx_overhead_insert_control[e1nb_pkg::POS_NB7];
  assign national_bit6_insert_enable = tx_overhead_insert_control[e1nb_pkg::POS_NB6];
  assign national_bit5_insert_enable = tx_overhead_insert_control[e1nb_pkg::POS_NB5];
  assign national_bit4_insert_enable = tx_overhead_insert_control[e1nb_pkg::POS_NB4];
  assign far_end_alarm_insert_enable = tx_overhead_insert_control[e1nb_pkg::POS_ALARM];
  assign intl_bit_nonalign_insert_enable = tx_overhead_insert_control[e1nb_pkg::SEL_INTL_NONALIGN];
  assign intl_bit_align_insert_enable = tx_overhead_insert_control[e1nb_pkg::SEL_INTL_ALIGN];

  // national registers and selectors gathered by their byte position
  assign national_frames[e1nb_pkg::POS_NB8] = tx_national_bit8_frames;
  assign national_frames[e1nb_pkg::POS_NB7] = tx_national_bit7_frames;
  assign national_frames[e1nb_pkg::POS_NB6] = tx_national_bit6_frames;
  assign national_frames[e1nb_pkg::POS_NB5] = tx_national_bit5_frames;
  assign national_frames[e1nb_pkg::POS_NB4] = tx_national_bit4_frames;
  assign national_enable[e1nb_pkg::POS_NB8] = national_bit8_insert_enable;
  assign national_enable[e1nb_pkg::POS_NB7] = national_bit7_insert_enable;
  assign national_enable[e1nb_pkg::POS_NB6] = national_bit6_insert_enable;
  assign national_enable[e1nb_pkg::POS_NB5] = national_bit5_insert_enable;
  assign national_enable[e1nb_pkg::POS_NB4] = national_bit4_insert_enable;

  assign slot = slot_of(in_frame); // R9 R10 R11 R12 R13
  assign align_frame = !in_frame[0];

  genvar gp;
  generate
    for (gp = 0; gp < e1nb_pkg::NUM_NATIONAL; gp = gp + 1)
    begin : g_national
      // R1 R2 R3 R4 R5 R15
      assign national_bits[gp] = national_enable[gp] ? national_frames[gp][slot] : in_ts0[gp];
    end
  endgenerate

  // overhead merge; align frames keep their sync pattern and change only the international bit
  always_comb
  begin
    merged_ts0 = in_ts0; // R15
    if (align_frame)
    begin
      if (intl_bit_align_insert_enable)
      begin
        merged_ts0[e1nb_pkg::POS_INTL] = tx_intl_bit_align_frames[slot]; // R8 R13 R14
      end
    end
    else
    begin
      merged_ts0[e1nb_pkg::POS_NB4:e1nb_pkg::POS_NB8] = national_bits;
      if (far_end_alarm_insert_enable)
      begin
        merged_ts0[e1nb_pkg::POS_ALARM] = tx_far_end_alarm_frames[slot]; // R6 R12
      end
      if (intl_bit_nonalign_insert_enable)
      begin
        merged_ts0[e1nb_pkg::POS_INTL] = tx_intl_bit_nonalign_frames[slot]; // R7 R14
      end
    end
  end

  // two-entry buffer keeps words when the receiver stalls
  assign push_if.valid = in_valid;
  assign push_if.word.frame = in_frame;
  assign push_if.word.ts0 = merged_ts0;
  assign pop_if.ready = out_ready;
  assign in_ready = push_if.ready;
  assign out_valid = pop_if.valid;
  assign out_frame = pop_if.word.frame;
  assign out_ts0 = pop_if.word.ts0;
  assign accept = in_valid && push_if.ready;

  e1nb_buf2 u_buf
  (
    .mclk(mclk),
    .rst(rst),
    .push(push_if.snk),
    .pop(pop_if.src)
  );

  // register writes
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_national_bit4_frames <= e1nb_pkg::RST_FRAMES;
    end
    else if (reg_wr && hit(reg_addr, e1nb_pkg::OFF_NATIONAL_BIT4))
    begin
      tx_national_bit4_frames <= reg_wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_national_bit5_frames <= e1nb_pkg::RST_FRAMES;
    end
    else if (reg_wr && hit(reg_addr, e1nb_pkg::OFF_NATIONAL_BIT5))
    begin
      tx_national_bit5_frames <= reg_wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_national_bit6_frames <= e1nb_pkg::RST_FRAMES;
    end
    else if (reg_wr && hit(reg_addr, e1nb_pkg::OFF_NATIONAL_BIT6))
    begin
      tx_national_bit6_frames <= reg_wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_national_bit7_frames <= e1nb_pkg::RST_FRAMES;
    end
    else if (reg_wr && hit(reg_addr, e1nb_pkg::OFF_NATIONAL_BIT7))
    begin
      tx_national_bit7_frames <= reg_wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_national_bit8_frames <= e1nb_pkg::RST_FRAMES;
    end
    else if (reg_wr && hit(reg_addr, e1nb_pkg::OFF_NATIONAL_BIT8))
    begin
      tx_national_bit8_frames <= reg_wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_far_end_alarm_frames <= e1nb_pkg::RST_FRAMES;
    end
    else if (reg_wr && hit(reg_addr, e1nb_pkg::OFF_FAR_END_ALARM))
    begin
      tx_far_end_alarm_frames <= reg_wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_intl_bit_align_frames <= e1nb_pkg::RST_FRAMES;
    end
    else if (reg_wr && hit(reg_addr, e1nb_pkg::OFF_INTL_ALIGN))
    begin
      tx_intl_bit_align_frames <= reg_wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_intl_bit_nonalign_frames <= e1nb_pkg::RST_FRAMES;
    end
    else if (reg_wr && hit(reg_addr, e1nb_pkg::OFF_INTL_NONALIGN))
    begin
      tx_intl_bit_nonalign_frames <= reg_wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_overhead_insert_control <= e1nb_pkg::RST_CONTROL;
    end
    else if (reg_wr && hit(reg_addr, e1nb_pkg::OFF_INSERT_CONTROL))
    begin
      tx_overhead_insert_control <= reg_wdata;
    end
  end

  // frame sequence watch: each accepted frame should follow the last by one
  assign seq_break = accept && have_last && (in_frame != last_frame + e1nb_pkg::FRAME_STEP);
  assign status_clear = reg_wr && hit(reg_addr, e1nb_pkg::OFF_STATUS) && reg_wdata[e1nb_pkg::STAT_SEQ_ERR];

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      have_last <= 1'b0;
      last_frame <= '0;
    end
    else if (accept)
    begin
      have_last <= 1'b1;
      last_frame <= in_frame;
    end
  end

  // a break in the same cycle as the clear keeps the flag set
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      seq_err <= 1'b0;
    end
    else if (seq_break)
    begin
      seq_err <= 1'b1;
    end
    else if (status_clear)
    begin
      seq_err <= 1'b0;
    end
  end

  always_comb
  begin
    status_value = '0;
    status_value[e1nb_pkg::STAT_SEQ_ERR] = seq_err;
    status_value[e1nb_pkg::STAT_OUT_PENDING] = pop_if.valid;
    status_value[e1nb_pkg::STAT_IN_READY] = push_if.ready;
    status_value[e1nb_pkg::STAT_LAST_HI:e1nb_pkg::STAT_LAST_LO] = last_frame;
  end

  // read mux; unmapped offsets read as zero
  always_comb
  begin
    next_rdata = e1nb_pkg::RST_READ;
    if (reg_rd)
    begin
      if (hit(reg_addr, e1nb_pkg::OFF_NATIONAL_BIT4))
      begin
        next_rdata = tx_national_bit4_frames;
      end
      else if (hit(reg_addr, e1nb_pkg::OFF_NATIONAL_BIT5))
      begin
        next_rdata = tx_national_bit5_frames;
      end
      else if (hit(reg_addr, e1nb_pkg::OFF_NATIONAL_BIT6))
      begin
        next_rdata = tx_national_bit6_frames;
      end
      else if (hit(reg_addr, e1nb_pkg::OFF_NATIONAL_BIT7))
      begin
        next_rdata = tx_national_bit7_frames;
      end
      else if (hit(reg_addr, e1nb_pkg::OFF_NATIONAL_BIT8))
      begin
        next_rdata = tx_national_bit8_frames;
      end
      else if (hit(reg_addr, e1nb_pkg::OFF_FAR_END_ALARM))
      begin
        next_rdata = tx_far_end_alarm_frames;
      end
      else if (hit(reg_addr, e1nb_pkg::OFF_INTL_ALIGN))
      begin
        next_rdata = tx_intl_bit_align_frames;
      end
      else if (hit(reg_addr, e1nb_pkg::OFF_INTL_NONALIGN))
      begin
        next_rdata = tx_intl_bit_nonalign_frames;
      end
      else if (hit(reg_addr, e1nb_pkg::OFF_INSERT_CONTROL))
      begin
        next_rdata = tx_overhead_insert_control;
      end
      else if (hit(reg_addr, e1nb_pkg::OFF_STATUS))
      begin
        next_rdata = status_value;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      reg_rdata <= e1nb_pkg::RST_READ;
    end
    else
    begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // e1nb_insert

// >>> e1nb_monitor.sv
`timescale 1ns/100ps
module e1nb_monitor
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // stream in
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic [e1nb_pkg::FRAME_W-1:0] in_frame,
  input wire logic [7:0] in_ts0,
  // stream out
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [e1nb_pkg::FRAME_W-1:0] out_frame,
  input wire logic [7:0] out_ts0
);
  logic [7:0] sh [0:8];
  logic [7:0] merged;
  logic [7:0] want;
  logic [7:0] rd_want;
  logic [3:0] ra;
  logic hit;
  logic acc;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  assign ra = 4'(reg_addr - 8'h42);
  assign hit = reg_addr >= 8'h42 && reg_addr <= 8'h4a;
  assign acc = in_valid && in_ready && (!out_valid || out_ready);
  // shadow copy of the writable registers
  always_ff @(posedge mclk)
  begin
    if (rst)
      sh <= '{default: 8'h00};
    else if (reg_wr && hit)
      sh[ra] <= reg_wdata;
  end
  always_ff @(posedge mclk)
  begin
    want <= merged;
    rd_want <= sh[ra];
  end
  always_comb
  begin
    merged = in_ts0;
    if (in_frame[0])
    begin
      for (int k = 0; k < 6; k++)
        if (sh[8][k])
          merged[k] = sh[7 - k][3'h7 - in_frame[3:1]];
      if (sh[8][6])
        merged[7] = sh[1][3'h7 - in_frame[3:1]];
    end
    else if (sh[8][7])
      merged[7] = sh[0][3'h7 - in_frame[3:1]];
  end
  sequence s_first;
    !out_valid && in_valid && in_ready && !out_ready;
  endsequence
  sequence s_second;
    in_valid && in_ready && !out_ready;
  endsequence
  property p_nb;
    acc |=> out_ts0[4:0] == want[4:0];
  endproperty
  property p_alarm;
    acc |=> out_ts0[5] == want[5];
  endproperty
  property p_intl;
    acc |=> out_ts0[7] == want[7];
  endproperty
  property p_keep;
    acc |=> out_ts0[6] == want[6];
  endproperty
  property p_take;
    acc |=> out_valid && out_frame == $past(in_frame);
  endproperty
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_ts0) && $stable(out_frame);
  endproperty
  property p_full;
    s_first ##1 s_second |=> !in_ready;
  endproperty
  property p_read;
    reg_rd && hit |=> reg_rdata == rd_want;
  endproperty
  property p_reset;
    disable iff (1'b0) rst |=> in_ready && !out_valid && reg_rdata == 8'h00;
  endproperty
  a_nb: assert property (p_nb) else $error("national bits wrong");
  a_alarm: assert property (p_alarm) else $error("alarm bit wrong");
  a_intl: assert property (p_intl) else $error("international bit wrong");
  a_keep: assert property (p_keep) else $error("bit 6 altered");
  a_take: assert property (p_take) else $error("word not forwarded");
  a_hold: assert property (p_hold) else $error("output changed while stalled");
  a_full: assert property (p_full) else $error("ready high with two words held");
  a_read: assert property (p_read) else $error("read data wrong");
  a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule // e1nb_monitor

bind e1nb_insert e1nb_monitor mon_u
(
  .mclk(mclk),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .in_valid(in_valid),
  .in_ready(in_ready),
  .in_frame(in_frame),
  .in_ts0(in_ts0),
  .out_valid(out_valid),
  .out_ready(out_ready),
  .out_frame(out_frame),
  .out_ts0(out_ts0)
);

// >>> e1nb_sink.sv
`timescale 1ns/100ps
module e1nb_sink
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // stall request
  input wire logic stall,
  // stream from the block
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [e1nb_pkg::FRAME_W-1:0] out_frame,
  input wire logic [7:0] out_ts0
);
  e1nb_pkg::e1nb_word_t got [$];
  initial out_ready = 1'b0;
  // collects every word taken, in order
  always @(posedge mclk)
  begin
    out_ready <= !rst && !stall;
    if (!rst && out_valid && out_ready)
      got.push_back('{frame: out_frame, ts0: out_ts0});
  end
endmodule // e1nb_sink

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
  typedef struct {
    logic [7:0] ctl;
    logic [3:0] frame;
    logic [7:0] ts0;
    logic [7:0] want;
  } e1nb_row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic in_valid = 1'b0;
  logic in_ready;
  logic [3:0] in_frame = 4'h0;
  logic [7:0] in_ts0 = 8'h00;
  logic out_valid;
  logic out_ready;
  logic [3:0] out_frame;
  logic [7:0] out_ts0;
  logic stall = 1'b0;
  int fail_count = 0;
  int compares = 0;
  logic [7:0] regv [0:7] = '{8'ha5, 8'h3c, 8'hf0, 8'h0f, 8'h55, 8'haa, 8'hcc, 8'h33};
  logic [7:0] ctls [0:9] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'hff};
  logic [7:0] sd [0:2] = '{8'h12, 8'h34, 8'h56};
  e1nb_row_t rows [0:159];
  e1nb_pkg::e1nb_word_t w;
  always #12.5 mclk = ~mclk;
  e1nb_insert dut_u
  (
    .mclk(mclk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_frame(in_frame),
    .in_ts0(in_ts0),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_frame(out_frame),
    .out_ts0(out_ts0)
  );
  e1nb_sink sink_u
  (
    .mclk(mclk),
    .rst(rst),
    .stall(stall),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_frame(out_frame),
    .out_ts0(out_ts0)
  );
  task automatic chk(input string what, input logic [7:0] want, input logic [7:0] got);
    compares++;
    if (got !== want)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, want, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk("reg_rdata", want, reg_rdata);
    @(posedge mclk);
  endtask
  task automatic send(input logic [3:0] f, input logic [7:0] d);
    int n;
    n = 0;
    in_valid <= 1'b1;
    in_frame <= f;
    in_ts0 <= d;
    @(negedge mclk);
    while (in_ready !== 1'b1 && n < 200)
    begin
      @(negedge mclk);
      n++;
    end
    // a block that never takes the byte ends the run as a failure
    if (n >= 200)
    begin
      fail_count++;
      final_report();
    end
    else
    begin
      @(posedge mclk);
    end
  endtask
  task automatic drain(input int cnt);
    int n;
    n = 0;
    in_valid <= 1'b0;
    while (sink_u.got.size() < cnt && n < 500)
    begin
      @(posedge mclk);
      n++;
    end
    if (sink_u.got.size() < cnt)
    begin
      fail_count++;
      final_report();
    end
  endtask
  // reference merge of one timeslot-0 byte
  function automatic logic [7:0] model(input logic [7:0] c, input logic [3:0] f, input logic [7:0] d);
    model = d;
    if (f[0])
    begin
      for (int k = 0; k < 6; k++)
        if (c[k])
          model[k] = regv[7 - k][3'h7 - f[3:1]];
      if (c[6])
        model[7] = regv[1][3'h7 - f[3:1]];
    end
    else if (c[7])
      model[7] = regv[0][3'h7 - f[3:1]];
  endfunction
  task automatic final_report;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #(25 * 20000);
    fail_count++;
    final_report();
  end
  initial
  begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int a = 8'h42; a <= 8'h4a; a++)
      rd(8'(a), 8'h00);
    rd(8'h50, 8'h00);
    for (int a = 0; a < 8; a++)
    begin
      wr(8'(a + 8'h42), regv[a]);
      rd(8'(a + 8'h42), regv[a]);
    end
    foreach (rows[r])
    begin
      rows[r] = '{ctls[r / 16], 4'(r % 16), 8'((r % 16) * 8'h11 ^ 8'h5a), 8'h00};
      rows[r].want = model(rows[r].ctl, rows[r].frame, rows[r].ts0);
    end
    foreach (rows[r])
    begin
      if (r % 16 == 0)
      begin
        wr(8'h4a, rows[r].ctl);
        rd(8'h4a, rows[r].ctl);
      end
      send(rows[r].frame, rows[r].ts0);
      if (r % 16 == 15)
      begin
        drain(16);
        for (int k = r - 15; k <= r; k++)
        begin
          w = sink_u.got.pop_front();
          chk("out_ts0", rows[k].want, w.ts0);
          chk("out_frame", {4'h0, rows[k].frame}, {4'h0, w.frame});
        end
      end
    end
    // receiver stalls: two words held, third refused until released
    stall <= 1'b1;
    repeat (2) @(posedge mclk);
    for (int k = 0; k < 2; k++)
      send(4'(k), sd[k]);
    in_frame <= 4'h2;
    in_ts0 <= sd[2];
    repeat (3)
    begin
      @(negedge mclk);
      chk("in_ready", 8'h00, {7'h00, in_ready});
    end
    // back on the rising edge before touching any input
    @(posedge mclk);
    stall <= 1'b0;
    send(4'h2, sd[2]);
    drain(3);
    for (int k = 0; k < 3; k++)
    begin
      w = sink_u.got.pop_front();
      chk("stalled out_ts0", model(8'hff, 4'(k), sd[k]), w.ts0);
      chk("stalled out_frame", 8'(k), {4'h0, w.frame});
    end
    // frame skip sets the sequence flag, write one clears it
    send(4'h9, 8'h00);
    drain(1);
    w = sink_u.got.pop_front();
    rd(8'h4b, 8'h95);
    wr(8'h4b, 8'h01);
    rd(8'h4b, 8'h94);
    // reset in mid-run
    wr(8'h4a, 8'h5a);
    rst <= 1'b1;
    reg_wr <= 1'b0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(8'h4a, 8'h00);
    final_report();
  end
endmodule // testbench
